// [hw/ccr_core_regs.sv]
/*
 * Programming-model register set of the 8-bit core: working byte, indexing
 * pointer, fetch address, return-stack index and flag register, with the
 * call, return and interrupt-entry sequencer that moves the fetch address
 * through the stack.
 * Assumes an instruction decoder and ALU outside that issue one command per
 * enabled cycle while CMD_READY_OUT is high, and a stack RAM whose read data
 * is valid in the same cycle as its address.
 */
`timescale 1ns/1ns

module ccr_core_regs (
   input wire logic REF_CLK_IN, // Core clock, 25 MHz.
   input wire logic RESETN_IN, // Synchronous reset, active low.
   input wire logic CLK_EN_IN, // Clock enable; low freezes all state.
   input wire ccr_pkg::ccr_cmd_e CMD_IN, // Decoded instruction command.
   output logic CMD_READY_OUT, // Command is taken this enabled cycle.
   input wire ccr_pkg::ccr_alu_s ALU_IN, // ALU result for CMD_ALU.
   input wire logic [7:0] ACC_D_IN, // Working byte for CMD_ACC.
   input wire logic [11:0] PTR_D_IN, // Pointer value for CMD_XLOAD.
   input wire logic CARRY_D_IN, // Bit for CMD_LDC.
   input wire logic [10:0] TARGET_IN, // Jump or call target.
   input wire logic PC_INC_IN, // Advance fetch address by one.
   input wire logic IRQ_PEND_IN, // A maskable request is pending.
   input wire logic [10:0] VECTOR_IN, // Vector of the request being entered.
   input wire logic EEP_BUSY_IN, // Data nonvolatile write in progress.
   input wire ccr_pkg::ccr_mem_req_s MEM_IN, // Data-space access.
   output logic MEM_HIT_OUT, // Access addresses a mapped register.
   output logic [7:0] MEM_RDATA_OUT, // Read data of the mapped register.
   input wire logic [7:0] IDX_OFS_IN, // Offset of an indexed access.
   input wire logic IDX_WR_IN, // Indexed write requested.
   output logic [11:0] EA_OUT, // Effective address of indexed access.
   output logic EA_PROG_OUT, // Effective address lies in program space.
   output logic IDX_WE_OUT, // Indexed write allowed to memory.
   output logic STK_WE_OUT, // Stack RAM write strobe.
   output logic [7:0] STK_ADDR_OUT, // Stack RAM address.
   output logic [7:0] STK_WDATA_OUT, // Stack RAM write data.
   input wire logic [7:0] STK_RDATA_IN, // Stack RAM read data.
   output logic IRQ_ACK_OUT, // Pulse when a maskable request is taken.
   output logic [7:0] ACC_OUT, // Working byte.
   output logic [11:0] PTR_OUT, // Indexing pointer.
   output logic [11:0] FETCH_ADDR_OUT, // Fetch address, program space.
   output logic [3:0] SP_OUT, // Stack index.
   output logic [7:0] FLAGS_OUT // Flag register.
);

   ////////////////////////////////////////////////////////////////////////
   ccr_pkg::ccr_state_s st_q;
   ccr_pkg::ccr_state_s st_d;
   logic [7:0] flags_rd;
   logic [10:0] ea_sum;
   logic idle;
   logic take_irq;

   assign idle = (st_q.seq == ccr_pkg::SEQ_IDLE);
   // The software interrupt does not wait for the mask, so only maskable
   // requests are gated here.
   assign take_irq = idle && IRQ_PEND_IN && st_q.flags[ccr_pkg::FLAG_IRQ_MASK];
   assign CMD_READY_OUT = idle && !take_irq;
   assign IRQ_ACK_OUT = take_irq && CLK_EN_IN;

   always_comb begin
      flags_rd = {2'b00, EEP_BUSY_IN, st_q.flags};
   end

   ////////////////////////////////////////////////////////////////////////
   // Indexed addressing adds to the low 11 bits; bit 11 picks the space.
   assign ea_sum = st_q.ptr[10:0] + {3'b000, IDX_OFS_IN};
   always_comb begin
      if (st_q.ptr[ccr_pkg::PTR_SPACE_BIT]) begin
         EA_OUT = ccr_pkg::PROG_SPACE_BASE | {1'b0, ea_sum};
      end else begin
         EA_OUT = ccr_pkg::DATA_SPACE_MASK & {1'b0, ea_sum};
      end
   end
   assign EA_PROG_OUT = st_q.ptr[ccr_pkg::PTR_SPACE_BIT];
   assign IDX_WE_OUT = IDX_WR_IN && !st_q.ptr[ccr_pkg::PTR_SPACE_BIT];

   ////////////////////////////////////////////////////////////////////////
   // Memory-mapped reads. Bit 11 of the pointer is write-only and reads 0.
   always_comb begin
      MEM_HIT_OUT = 1'b1;
      case (MEM_IN.addr)
         ccr_pkg::ADDR_PTR_UPPER: begin
            MEM_RDATA_OUT = {5'b00000, st_q.ptr[10:8]};
         end
         ccr_pkg::ADDR_PTR_LOWER: begin
            MEM_RDATA_OUT = st_q.ptr[7:0];
         end
         ccr_pkg::ADDR_STACK_INDEX: begin
            MEM_RDATA_OUT = {4'h0, st_q.sp};
         end
         ccr_pkg::ADDR_FLAGS: begin
            MEM_RDATA_OUT = flags_rd;
         end
         default: begin
            MEM_HIT_OUT = 1'b0;
            MEM_RDATA_OUT = 8'h00;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   // Stack port. Push writes the low byte at the index and the high byte
   // one below; pull reads them back in reverse order.
   always_comb begin
      STK_WE_OUT = 1'b0;
      STK_ADDR_OUT = {ccr_pkg::STACK_PAGE, st_q.sp};
      STK_WDATA_OUT = 8'h00;
      case (st_q.seq)
         ccr_pkg::SEQ_PUSH_LO: begin
            STK_WE_OUT = CLK_EN_IN;
            STK_WDATA_OUT = st_q.pc[7:0];
         end
         ccr_pkg::SEQ_PUSH_HI: begin
            STK_WE_OUT = CLK_EN_IN;
            STK_ADDR_OUT = {ccr_pkg::STACK_PAGE, st_q.sp - 4'h1};
            STK_WDATA_OUT = {5'b00000, st_q.pc[10:8]};
         end
         ccr_pkg::SEQ_PULL_HI: begin
            STK_ADDR_OUT = {ccr_pkg::STACK_PAGE, st_q.sp + 4'h1};
         end
         ccr_pkg::SEQ_PULL_LO: begin
            STK_ADDR_OUT = {ccr_pkg::STACK_PAGE, st_q.sp + ccr_pkg::STACK_STEP};
         end
         default: begin
            STK_WE_OUT = 1'b0;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_comb begin
      st_d = st_q;
      if (PC_INC_IN && idle) begin
         st_d.pc = st_q.pc + 11'h001;
      end
      case (st_q.seq)
         ccr_pkg::SEQ_IDLE: begin
            if (take_irq) begin
               st_d.seq = ccr_pkg::SEQ_PUSH_LO;
               st_d.is_irq = 1'b1;
               st_d.pc = st_q.pc;
            end else begin
               case (CMD_IN)
                  ccr_pkg::CMD_CALL: begin
                     st_d.seq = ccr_pkg::SEQ_PUSH_LO;
                     st_d.is_irq = 1'b0;
                     st_d.target = TARGET_IN;
                  end
                  ccr_pkg::CMD_SWI: begin
                     st_d.seq = ccr_pkg::SEQ_PUSH_LO;
                     st_d.is_irq = 1'b1;
                  end
                  ccr_pkg::CMD_RET: begin
                     st_d.seq = ccr_pkg::SEQ_PULL_HI;
                     st_d.is_irq_exit_op = 1'b0;
                  end
                  ccr_pkg::CMD_IRQ_EXIT_OP: begin
                     st_d.seq = ccr_pkg::SEQ_PULL_HI;
                     st_d.is_irq_exit_op = 1'b1;
                  end
                  ccr_pkg::CMD_SETC: begin
                     st_d.flags[ccr_pkg::FLAG_CARRY] = 1'b1;
                  end
                  ccr_pkg::CMD_CLRC: begin
                     st_d.flags[ccr_pkg::FLAG_CARRY] = 1'b0;
                  end
                  ccr_pkg::CMD_LDC: begin
                     st_d.flags[ccr_pkg::FLAG_CARRY] = CARRY_D_IN;
                  end
                  ccr_pkg::CMD_TOGGLE_CARRY_OP: begin
                     st_d.flags[ccr_pkg::FLAG_CARRY] = !st_q.flags[ccr_pkg::FLAG_CARRY];
                  end
                  ccr_pkg::CMD_XLOAD: begin
                     st_d.ptr = PTR_D_IN;
                  end
                  ccr_pkg::CMD_XINC: begin
                     st_d.ptr[10:0] = st_q.ptr[10:0] + 11'h001;
                  end
                  ccr_pkg::CMD_XDEC: begin
                     st_d.ptr[10:0] = st_q.ptr[10:0] - 11'h001;
                  end
                  ccr_pkg::CMD_ALU: begin
                     st_d.flags[ccr_pkg::FLAG_ZERO] = (ALU_IN.result == 8'h00);
                     st_d.flags[ccr_pkg::FLAG_SIGN] = ALU_IN.result[7];
                     if (ALU_IN.carry_upd) begin
                        st_d.flags[ccr_pkg::FLAG_CARRY] = ALU_IN.carry;
                     end
                     if (ALU_IN.half_upd) begin
                        st_d.flags[ccr_pkg::FLAG_HALF] = ALU_IN.half;
                     end
                     if (ALU_IN.write_acc) begin
                        st_d.acc = ALU_IN.result;
                     end
                  end
                  ccr_pkg::CMD_ACC: begin
                     st_d.acc = ACC_D_IN;
                  end
                  ccr_pkg::CMD_JUMP: begin
                     st_d.pc = TARGET_IN;
                  end
                  ccr_pkg::CMD_SETG: begin
                     st_d.flags[ccr_pkg::FLAG_IRQ_MASK] = 1'b1;
                  end
                  default: begin
                     st_d.seq = ccr_pkg::SEQ_IDLE;
                  end
               endcase
               // Software stores reach the mapped registers only between
               // sequences, so a stack move never races a store.
               if (MEM_IN.wr) begin
                  case (MEM_IN.addr)
                     ccr_pkg::ADDR_PTR_UPPER: begin
                        st_d.ptr[11:8] = MEM_IN.wdata[3:0];
                     end
                     ccr_pkg::ADDR_PTR_LOWER: begin
                        st_d.ptr[7:0] = MEM_IN.wdata;
                     end
                     ccr_pkg::ADDR_STACK_INDEX: begin
                        st_d.sp = MEM_IN.wdata[3:0];
                     end
                     ccr_pkg::ADDR_FLAGS: begin
                        st_d.flags = MEM_IN.wdata[4:0] & ccr_pkg::FLAG_WR_MASK[4:0];
                     end
                     default: begin
                        st_d.sp = st_d.sp;
                     end
                  endcase
               end
            end
         end
         ccr_pkg::SEQ_PUSH_LO: begin
            st_d.seq = ccr_pkg::SEQ_PUSH_HI;
         end
         ccr_pkg::SEQ_PUSH_HI: begin
            st_d.sp = st_q.sp - ccr_pkg::STACK_STEP;
            if (st_q.is_irq) begin
               st_d.seq = ccr_pkg::SEQ_VEC_1;
            end else begin
               st_d.seq = ccr_pkg::SEQ_IDLE;
               st_d.pc = st_q.target;
            end
         end
         ccr_pkg::SEQ_VEC_1: begin
            st_d.seq = ccr_pkg::SEQ_VEC_2;
         end
         ccr_pkg::SEQ_VEC_2: begin
            st_d.seq = ccr_pkg::SEQ_LOAD_VEC;
         end
         ccr_pkg::SEQ_LOAD_VEC: begin
            st_d.seq = ccr_pkg::SEQ_IDLE;
            st_d.pc = VECTOR_IN;
            st_d.flags[ccr_pkg::FLAG_IRQ_MASK] = 1'b0;
         end
         ccr_pkg::SEQ_PULL_HI: begin
            st_d.seq = ccr_pkg::SEQ_PULL_LO;
            st_d.pull_hi = STK_RDATA_IN;
         end
         ccr_pkg::SEQ_PULL_LO: begin
            st_d.seq = ccr_pkg::SEQ_IDLE;
            st_d.pc = {st_q.pull_hi[2:0], STK_RDATA_IN};
            st_d.sp = st_q.sp + ccr_pkg::STACK_STEP;
            if (st_q.is_irq_exit_op) begin
               st_d.flags[ccr_pkg::FLAG_IRQ_MASK] = 1'b1;
            end
         end
         default: begin
            st_d.seq = ccr_pkg::SEQ_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////
   always_ff @(posedge REF_CLK_IN) begin
      if (!RESETN_IN) begin
         st_q.acc <= ccr_pkg::ACC_RST;
         st_q.ptr <= ccr_pkg::PTR_RST;
         st_q.pc <= ccr_pkg::FETCH_ADDR_RST[10:0];
         st_q.sp <= ccr_pkg::STACK_INDEX_RST;
         st_q.flags <= 5'b00000;
         st_q.seq <= ccr_pkg::SEQ_IDLE;
         st_q.is_irq <= 1'b0;
         st_q.is_irq_exit_op <= 1'b0;
         st_q.target <= 11'h000;
         st_q.pull_hi <= 8'h00;
      end else if (CLK_EN_IN) begin
         st_q <= st_d;
      end
   end

   assign ACC_OUT = st_q.acc;
   assign PTR_OUT = st_q.ptr;
   // The fetch address always lies in program space, so its top bit is 1.
   assign FETCH_ADDR_OUT = ccr_pkg::PROG_SPACE_BASE | {1'b0, st_q.pc};
   assign SP_OUT = st_q.sp;
   assign FLAGS_OUT = flags_rd;

endmodule // ccr_core_regs

// [hw/ccr_pkg.sv]
/*
 * Shared constants and types of the core register set: memory-mapped
 * locations, flag layout, reset values, commands and sequencer states.
 * Assumes a single core clock and that every user of it names items as
 * ccr_pkg::name.
 */
package ccr_pkg;

   ////////////////////////////////////////////////////////////////////////
   // Memory-mapped locations in data space.
   localparam logic [7:0] ADDR_PTR_UPPER = 8'hBE;
   localparam logic [7:0] ADDR_PTR_LOWER = 8'hBF;
   localparam logic [7:0] ADDR_STACK_INDEX = 8'hBD;
   localparam logic [7:0] ADDR_FLAGS = 8'hBC;

   // The stack occupies one 16-byte page; the index supplies the low nibble.
   localparam logic [3:0] STACK_PAGE = 4'h3;
   localparam logic [3:0] STACK_INDEX_RST = 4'hF;
   localparam logic [3:0] STACK_STEP = 4'h2;

   ////////////////////////////////////////////////////////////////////////
   // Flag register bit positions.
   localparam int FLAG_CARRY = 0;
   localparam int FLAG_HALF = 1;
   localparam int FLAG_ZERO = 2;
   localparam int FLAG_SIGN = 3;
   localparam int FLAG_IRQ_MASK = 4;
   localparam int FLAG_EEP_BUSY = 5;
   // Bits software may write; the busy bit and bits 7:6 are not.
   localparam logic [7:0] FLAG_WR_MASK = 8'h1F;

   ////////////////////////////////////////////////////////////////////////
   // Pointer layout, address spaces and register reset values.
   localparam int PTR_SPACE_BIT = 11;
   localparam logic [11:0] FETCH_ADDR_RST = 12'h800;
   localparam logic [11:0] PROG_SPACE_BASE = 12'h800;
   localparam logic [11:0] DATA_SPACE_MASK = 12'h0FF;
   localparam logic [7:0] ACC_RST = 8'h00;
   localparam logic [11:0] PTR_RST = 12'h000;

   ////////////////////////////////////////////////////////////////////////
   // Commands presented by the instruction decoder.
   typedef enum logic [3:0] {
      CMD_NOP = 4'b0000,
      CMD_CALL = 4'b0001,
      CMD_RET = 4'b0010,
      CMD_IRQ_EXIT_OP = 4'b0011,
      CMD_SWI = 4'b0100,
      CMD_SETC = 4'b0101,
      CMD_CLRC = 4'b0110,
      CMD_LDC = 4'b0111,
      CMD_TOGGLE_CARRY_OP = 4'b1000,
      CMD_XLOAD = 4'b1001,
      CMD_XINC = 4'b1010,
      CMD_XDEC = 4'b1011,
      CMD_ALU = 4'b1100,
      CMD_ACC = 4'b1101,
      CMD_JUMP = 4'b1110,
      CMD_SETG = 4'b1111
   } ccr_cmd_e;

   typedef enum logic [2:0] {
      SEQ_IDLE = 3'b000,
      SEQ_PUSH_LO = 3'b001,
      SEQ_PUSH_HI = 3'b010,
      SEQ_VEC_1 = 3'b011,
      SEQ_VEC_2 = 3'b100,
      SEQ_LOAD_VEC = 3'b101,
      SEQ_PULL_HI = 3'b110,
      SEQ_PULL_LO = 3'b111
   } ccr_seq_e;

   // Result of one ALU operation, as delivered with CMD_ALU.
   typedef struct packed {
      logic [7:0] result;
      logic carry;
      logic carry_upd;
      logic half;
      logic half_upd;
      logic write_acc;
   } ccr_alu_s;

   // Data-space port of the memory-mapped locations.
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [7:0] wdata;
   } ccr_mem_req_s;

   typedef struct packed {
      logic [7:0] acc;
      logic [11:0] ptr;
      logic [10:0] pc;
      logic [3:0] sp;
      logic [4:0] flags;
      ccr_seq_e seq;
      logic is_irq;
      logic is_irq_exit_op;
      logic [10:0] target;
      logic [7:0] pull_hi;
   } ccr_state_s;

endpackage

// [verif/ccr_core_regs_chk.sv]
/* Assertions on the ports of ccr_core_regs, bound below.
   Assumes the bench keeps CLK_EN_IN high. */
`timescale 1ns/1ns
module ccr_core_regs_chk (
   input wire logic REF_CLK_IN, // Clock.
   input wire logic RESETN_IN, // Reset.
   input wire logic CLK_EN_IN, // Enable.
   input wire ccr_pkg::ccr_cmd_e CMD_IN, // Command.
   input wire logic CMD_READY_OUT, // Ready.
   input wire logic IRQ_PEND_IN, // Request.
   input wire logic IRQ_ACK_OUT, // Taken.
   input wire ccr_pkg::ccr_mem_req_s MEM_IN, // Data port.
   input wire logic [7:0] FLAGS_OUT, // Flags.
   input wire logic EEP_BUSY_IN, // Busy.
   input wire logic [3:0] SP_OUT, // Stack index.
   input wire logic [7:0] STK_ADDR_OUT, // Stack address.
   input wire logic STK_WE_OUT, // Stack write.
   input wire logic [11:0] FETCH_ADDR_OUT, // Fetch address.
   input wire logic [11:0] PTR_OUT, // Pointer.
   input wire logic [11:0] EA_OUT, // Indexed address.
   input wire logic [7:0] IDX_OFS_IN, // Offset.
   input wire logic IDX_WR_IN, // Indexed write.
   input wire logic IDX_WE_OUT // Write allowed.
);
   default clocking @(posedge REF_CLK_IN); endclocking
   default disable iff (!RESETN_IN);
   wire take = CLK_EN_IN && CMD_READY_OUT;
   a_reset_value: assert property (
      $rose(RESETN_IN) |-> SP_OUT == 4'hF && FETCH_ADDR_OUT == 12'h800 && !FLAGS_OUT[4])
      else $error("reset values wrong");
   a_call_push: assert property (
      take && CMD_IN == ccr_pkg::CMD_CALL |=> STK_WE_OUT && STK_ADDR_OUT == {4'h3, $past(SP_OUT)}
      ##1 STK_WE_OUT && STK_ADDR_OUT == {4'h3, $past(SP_OUT, 2) - 4'h1}
      ##1 CMD_READY_OUT && SP_OUT == $past(SP_OUT, 3) - 4'h2) else $error("call push wrong");
   a_ret_pull: assert property (
      take && CMD_IN inside {ccr_pkg::CMD_RET, ccr_pkg::CMD_IRQ_EXIT_OP}
      |=> !STK_WE_OUT && STK_ADDR_OUT == {4'h3, $past(SP_OUT) + 4'h1}
      ##1 !STK_WE_OUT && STK_ADDR_OUT == {4'h3, $past(SP_OUT, 2) + 4'h2}
      ##1 SP_OUT == $past(SP_OUT, 3) + 4'h2) else $error("return pull wrong");
   a_irq_entry: assert property (
      IRQ_ACK_OUT |-> !CMD_READY_OUT ##1 !CMD_READY_OUT[*5] ##1 CMD_READY_OUT && !FLAGS_OUT[4]
      && SP_OUT == $past(SP_OUT, 6) - 4'h2) else $error("irq entry wrong");
   a_soft_entry: assert property (
      take && CMD_IN == ccr_pkg::CMD_SWI |=> !CMD_READY_OUT[*5] ##1 CMD_READY_OUT
      && !FLAGS_OUT[4]) else $error("soft irq entry wrong");
   a_mask_wait: assert property (
      IRQ_ACK_OUT |-> IRQ_PEND_IN && FLAGS_OUT[4]) else $error("masked irq taken");
   a_mask_source: assert property (
      $rose(FLAGS_OUT[4]) |-> $past(CMD_IN) == ccr_pkg::CMD_SETG || $past(MEM_IN.wr)
      || !$past(CMD_READY_OUT)) else $error("mask set without software");
   a_ptr_count: assert property (
      take && CMD_IN inside {ccr_pkg::CMD_XINC, ccr_pkg::CMD_XDEC} |=> PTR_OUT[11] ==
      $past(PTR_OUT[11]) && PTR_OUT[10:0] == ($past(CMD_IN) == ccr_pkg::CMD_XINC ?
      $past(PTR_OUT[10:0]) + 11'h1 : $past(PTR_OUT[10:0]) - 11'h1)) else $error("count wrong");
   a_ea_calc: assert property (
      EA_OUT == (PTR_OUT[11] ? {1'b1, PTR_OUT[10:0] + {3'h0, IDX_OFS_IN}}
      : {4'h0, PTR_OUT[7:0] + IDX_OFS_IN})) else $error("indexed address wrong");
   a_idx_guard: assert property (
      IDX_WE_OUT == (IDX_WR_IN && !PTR_OUT[11])) else $error("program space written");
   a_busy_flag: assert property (
      FLAGS_OUT[5] == EEP_BUSY_IN && FLAGS_OUT[7:6] == 2'b00) else $error("flag top wrong");
   c_call: cover property (take && CMD_IN == ccr_pkg::CMD_CALL);
   c_irq: cover property (IRQ_ACK_OUT);
   c_soft: cover property (take && CMD_IN == ccr_pkg::CMD_SWI);
endmodule // ccr_core_regs_chk

bind ccr_core_regs ccr_core_regs_chk i_ccr_core_regs_chk (.REF_CLK_IN, .RESETN_IN,
   .CLK_EN_IN, .CMD_IN, .CMD_READY_OUT, .IRQ_PEND_IN, .IRQ_ACK_OUT, .MEM_IN, .FLAGS_OUT,
   .EEP_BUSY_IN, .SP_OUT, .STK_ADDR_OUT, .STK_WE_OUT, .FETCH_ADDR_OUT, .PTR_OUT, .EA_OUT,
   .IDX_OFS_IN, .IDX_WR_IN, .IDX_WE_OUT);

// [verif/testbench.sv]
/* Bench of ccr_core_regs: integer model, stack RAM, random commands.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ns
module testbench;
   logic ref_clk, resetn, eep_busy, pc_inc, irq_pend, carry_d, idx_wr, ready, hit, ack;
   logic stk_we, ea_prog, idx_we;
   logic [7:0] acc_d, idx_ofs, rdata, stk_addr, stk_wdata, stk_rd, acc_o, flags_o;
   logic [11:0] ptr_d, ea, ptr_o, fetch;
   logic [10:0] target, vector;
   logic [3:0] sp_o;
   ccr_pkg::ccr_cmd_e cmd;
   ccr_pkg::ccr_alu_s alu;
   ccr_pkg::ccr_mem_req_s mem;
   logic [7:0] ram [0:255];
   int mram [0:255];
   int failures, n_compared, cyc, m_acc, m_ptr, m_pc, m_sp;
   bit m_c, m_h, m_z, m_n, m_g, zn_ok;

   ccr_core_regs i_ccr_core_regs (.REF_CLK_IN(ref_clk), .RESETN_IN(resetn), .CLK_EN_IN(1'b1),
      .CMD_IN(cmd), .CMD_READY_OUT(ready), .ALU_IN(alu), .ACC_D_IN(acc_d), .PTR_D_IN(ptr_d),
      .CARRY_D_IN(carry_d), .TARGET_IN(target), .PC_INC_IN(pc_inc), .IRQ_PEND_IN(irq_pend),
      .VECTOR_IN(vector), .EEP_BUSY_IN(eep_busy), .MEM_IN(mem), .MEM_HIT_OUT(hit),
      .MEM_RDATA_OUT(rdata), .IDX_OFS_IN(idx_ofs), .IDX_WR_IN(idx_wr), .EA_OUT(ea),
      .EA_PROG_OUT(ea_prog), .IDX_WE_OUT(idx_we), .STK_WE_OUT(stk_we), .STK_ADDR_OUT(stk_addr),
      .STK_WDATA_OUT(stk_wdata), .STK_RDATA_IN(stk_rd), .IRQ_ACK_OUT(ack), .ACC_OUT(acc_o),
      .PTR_OUT(ptr_o), .FETCH_ADDR_OUT(fetch), .SP_OUT(sp_o), .FLAGS_OUT(flags_o));

   // Stack RAM with asynchronous read, as the core expects.
   assign stk_rd = ram[stk_addr];
   always @(posedge ref_clk) if (stk_we) ram[stk_addr] <= stk_wdata;
   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   ////////////////////////////////////////////////////////////////////////////
   task automatic give_verdict;
      $display("compared %0d, mismatches %0d", n_compared, failures);
      if (failures == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   always @(posedge ref_clk) begin
      cyc++;
      if (cyc == 10000) begin
         failures++;
         give_verdict();
      end
   end
   task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic m_reset;
      {m_acc, m_ptr, m_pc, m_sp} = {32'd0, 32'd0, 32'd0, 32'd15};
      {m_c, m_h, m_z, m_n, m_g, zn_ok} = 6'b000001;
   endtask
   task automatic chk_all;
      cmp(acc_o, m_acc);
      cmp(ptr_o, m_ptr);
      cmp(ea_prog, m_ptr >> 11);
      cmp(fetch, 2048 | m_pc);
      cmp(sp_o, m_sp);
      cmp(flags_o & (zn_ok ? 8'hFF : 8'hF3),
          {2'b00, eep_busy, m_g, m_n & zn_ok, m_z & zn_ok, m_h, m_c});
      cmp(ea, (m_ptr & 2048) ? 2048 | ((m_ptr + idx_ofs) & 2047) : (m_ptr + idx_ofs) & 255);
      cmp(idx_we, idx_wr && m_ptr < 2048);
   endtask
   task automatic push;
      mram[48 + m_sp] = m_pc & 255;
      mram[48 + ((m_sp - 1) & 15)] = m_pc >> 8;
      m_sp = (m_sp - 2) & 15;
   endtask
   task automatic step(input ccr_pkg::ccr_cmd_e c);
      case (c)
         ccr_pkg::CMD_CALL: begin push(); m_pc = target; end
         ccr_pkg::CMD_SWI: begin push(); m_pc = vector; m_g = 0; end
         ccr_pkg::CMD_RET, ccr_pkg::CMD_IRQ_EXIT_OP: begin
            m_pc = ((mram[48 + ((m_sp + 1) & 15)] & 7) << 8) | mram[48 + ((m_sp + 2) & 15)];
            m_sp = (m_sp + 2) & 15;
            if (c == ccr_pkg::CMD_IRQ_EXIT_OP) m_g = 1;
         end
         ccr_pkg::CMD_SETC: m_c = 1;
         ccr_pkg::CMD_CLRC: m_c = 0;
         ccr_pkg::CMD_LDC: m_c = carry_d;
         ccr_pkg::CMD_TOGGLE_CARRY_OP: m_c = !m_c;
         ccr_pkg::CMD_XLOAD: m_ptr = ptr_d;
         ccr_pkg::CMD_XINC: m_ptr = (m_ptr & 2048) | ((m_ptr + 1) & 2047);
         ccr_pkg::CMD_XDEC: m_ptr = (m_ptr & 2048) | ((m_ptr - 1) & 2047);
         ccr_pkg::CMD_ALU: begin
            if (alu.carry_upd) m_c = alu.carry;
            if (alu.half_upd) m_h = alu.half;
            // Zero and sign follow every ALU result, written back or not.
            zn_ok = 1;
            m_z = alu.result == 8'h00;
            m_n = alu.result[7];
            if (alu.write_acc) m_acc = alu.result;
         end
         ccr_pkg::CMD_ACC: begin m_acc = acc_d; zn_ok = 0; end
         ccr_pkg::CMD_JUMP: m_pc = target;
         ccr_pkg::CMD_SETG: m_g = 1;
         default: if (pc_inc) m_pc = (m_pc + 1) & 2047;
      endcase
   endtask
   // A command offered while busy must be refused, so TOGGLE_CARRY_OP is left on the port then.
   task automatic issue(input ccr_pkg::ccr_cmd_e c);
      int k;
      bit p;
      p = $urandom_range(3) == 0;
      cmd <= c;
      irq_pend <= p;
      pc_inc <= c == ccr_pkg::CMD_NOP && !(p && m_g);
      alu <= 13'($urandom);
      {acc_d, carry_d, idx_wr, eep_busy} <= 11'($urandom);
      {ptr_d, idx_ofs} <= 20'($urandom);
      {target, vector} <= 22'($urandom);
      #1;
      cmp(ack, p && m_g);
      @(posedge ref_clk);
      cmd <= ccr_pkg::CMD_TOGGLE_CARRY_OP;
      irq_pend <= 1'b0;
      pc_inc <= 1'b0;
      step((p && m_g) ? ccr_pkg::CMD_SWI : c);
      k = 0;
      #1;
      while (ready !== 1'b1 && k < 20) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      cmd <= ccr_pkg::CMD_NOP;
      cmp(ready, 1'b1);
      chk_all();
      @(posedge ref_clk);
      #1;
   endtask
   task automatic mem_wr(input logic [7:0] a, input logic [7:0] d);
      mem <= '{1'b0, 1'b1, a, d};
      @(posedge ref_clk);
      mem <= '0;
      #1;
   endtask
   task automatic mem_rd(input logic [7:0] a, input logic [7:0] e);
      mem <= '{1'b1, 1'b0, a, 8'h00};
      #1;
      cmp(rdata, e);
      cmp(hit, a[7:2] == 6'h2F);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   initial begin
      void'($urandom(32'h38634a58));
      {resetn, eep_busy, pc_inc, irq_pend, carry_d, idx_wr} = '0;
      {acc_d, idx_ofs, ptr_d, target, vector, alu, mem} = '0;
      cmd = ccr_pkg::CMD_NOP;
      for (int i = 0; i < 256; i++) begin
         ram[i] = 8'(i * 7);
         mram[i] = (i * 7) & 255;
      end
      repeat (20) @(posedge ref_clk);
      resetn <= 1'b1;
      #1;
      m_reset();
      chk_all();
      mem_wr(8'hBF, 8'hA5);
      mem_wr(8'hBE, 8'hF9);
      m_ptr = 12'h9A5;
      mem_rd(8'hBE, 8'h01);
      mem_rd(8'hBF, 8'hA5);
      mem_wr(8'hBD, 8'h07);
      m_sp = 7;
      mem_rd(8'hBD, 8'h07);
      eep_busy <= 1'b1;
      mem_wr(8'hBC, 8'hFF);
      mem_rd(8'hBC, 8'h3F);
      mem_rd(8'h40, 8'h00);
      mem_wr(8'hBC, 8'h10);
      {m_c, m_h, m_z, m_n, m_g} = 5'b00001;
      chk_all();
      for (int i = 0; i < 400; i++) begin
         issue(ccr_pkg::ccr_cmd_e'(4'($urandom)));
      end
      resetn <= 1'b0;
      @(posedge ref_clk);
      resetn <= 1'b1;
      #1;
      m_reset();
      chk_all();
      give_verdict();
   end
endmodule // testbench
